/* rtl/energy_detector.sv */
// IIR energy detector with hysteresis and programmable listening time
module energy_detector
  import phy_link_supervision_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] strength_in,
  input  wire logic [3:0] threshold_in,
  input  wire logic [3:0] listen_in,
  output logic            energy_out
);
  logic [11:0] iir_q;
  logic [7:0]  lvl;
  logic [4:0]  listen_cnt_q;
  logic [7:0]  on_thr;
  logic [7:0]  off_thr;

  assign lvl     = iir_q[11:4];
  assign on_thr  = {threshold_in, 4'h0} + 8'(ED_HYST * 8);
  assign off_thr = {threshold_in, 4'h0};

  // First-order IIR: y += (x - y)/16
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iir_q <= 12'h000;
    end else begin
      iir_q <= iir_q - 12'(iir_q >> 4) + 12'(strength_in);
    end
  end

  // Hysteresis plus listening time keeps the indication from chattering
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      energy_out   <= 1'b0;
      listen_cnt_q <= 5'h00;
    end else if ((!energy_out && lvl >= on_thr) || (energy_out && lvl < off_thr)) begin
      if (listen_cnt_q >= {1'b0, listen_in}) begin
        energy_out   <= !energy_out;
        listen_cnt_q <= 5'h00;
      end else begin
        listen_cnt_q <= listen_cnt_q + 5'h01;
      end
    end else begin
      listen_cnt_q <= 5'h00;
    end
  end

  a_ed_stable: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $changed(energy_out) |=> $stable(energy_out)) else $error("energy flag chattered");
endmodule // energy_detector

/* rtl/phy_link_supervision.sv */
// Link supervision: link drop, downshift, mirroring, test modes, straps, registers
//
// Function
// - Default link-loss window: 1 ms at 100, 0.5 ms at gigabit.
// - Fast link-down shrinks the window to 10 us.
// - Fast mode drops link on any enabled criterion, freely combined.
// - Energy detect compares IIR filtered strength with hysteresis.
// - Energy thresholds and listening times are programmable.
// - Downshift to 100 after configurable failed gigabit attempts, default four.
// - Enhanced downshift after one failure when C and D lack energy.
// - Fall back to 10 after failures at gigabit and 100.
// - Mirror at 10/100 maps A to D, B to C either pinout.
// - Mirror at gigabit maps A-D, B-C, C-B, D-A.
// - Mirror enabled by strap or port_feature_config bit.
// - Interrupt on status change, sources selected by mask and status.
// - Four gigabit test modes plus normal via test_mode_config.
// - Test mode drives patterns and a synchronous clock out.
// - Straps sampled at power-up and hard reset.
// - Software reset reloads latched straps without resampling.
// - Fast link establishment modes configured in fast_link_config.
// - Passive cable-length estimate from receive-pair adaptation data.
module phy_link_supervision
  import phy_link_supervision_pkg::*;
#(
  parameter int WIN_100_CYCLES  = WIN_100_CYC,
  parameter int WIN_1000_CYCLES = WIN_1000_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        soft_rst_in,
  input  wire logic        strap_mirror_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic [4:0]  loss_crit_in,
  input  wire logic        rx_activity_in,
  input  wire logic        link_ok_in,
  input  wire logic        attempt_fail_in,
  input  wire logic [7:0]  strength_in,
  input  wire logic        energy_cd_in,
  input  wire logic [7:0]  adapt_len_in,
  input  wire logic        straight_pinout_in,
  input  wire logic [3:0]  port_tx_in,
  input  wire logic [3:0]  pattern_in,
  input  wire logic        tx_clk_in,
  output logic [15:0]      reg_rdata_out,
  output logic             link_down_out,
  output logic [1:0]       speed_out,
  output logic [3:0]       port_out,
  output logic             clk_out,
  output logic             fast_1000_out,
  output logic             fast_100_out,
  output logic             irq_out
);
  logic [15:0] test_mode_config_q;
  logic [15:0] interrupt_mask_q;
  logic [15:0] interrupt_status_q;
  logic [15:0] fast_link_config_q;
  logic [15:0] port_feature_config_q;
  logic        strap_mirror_q;
  logic        strap_taken_q;
  logic [31:0] win_cnt_q;
  logic        seen_q;
  logic        drop_q;
  logic [2:0]  fail_cnt_q;
  speed_t      speed_q;
  logic [7:0]  cable_len_q;
  logic        energy;
  logic        energy_q;
  logic        fast_mode;
  logic        crit_hit;
  logic        win_end;
  logic        loss_ev;
  logic        down_ev;
  logic        mirror_en;
  logic [2:0]  test_mode;
  logic [31:0] win_len;
  logic        wr_sts;

  function automatic logic [3:0] mirror_map(input logic [3:0] p, input speed_t s);
    // Index 0..3 stands for ports A..D
    if (s == SPD_1000) begin
      mirror_map = {p[0], p[1], p[2], p[3]};
    end else begin
      mirror_map = {p[0], p[1], 2'b00};
    end
  endfunction

  // Straps are caught after hard reset release; soft reset reuses them
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      strap_taken_q  <= 1'b0;
      strap_mirror_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q  <= 1'b1;
      strap_mirror_q <= strap_mirror_in;
    end
  end

  // Configuration registers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      test_mode_config_q    <= RST_TEST_MODE_CONFIG;
      interrupt_mask_q      <= RST_INTERRUPT_MASK;
      fast_link_config_q    <= RST_FAST_LINK_CONFIG;
      port_feature_config_q <= RST_PORT_FEATURE_CONFIG | 16'(RST_ATTEMPTS_M1 << PF_ATT_LSB);
    end else if (soft_rst_in || !strap_taken_q) begin
      test_mode_config_q    <= RST_TEST_MODE_CONFIG;
      interrupt_mask_q      <= RST_INTERRUPT_MASK;
      fast_link_config_q    <= RST_FAST_LINK_CONFIG;
      port_feature_config_q <= (RST_PORT_FEATURE_CONFIG | 16'(RST_ATTEMPTS_M1 << PF_ATT_LSB))
                               | 16'(strap_taken_q ? strap_mirror_q : strap_mirror_in);
    end else if (reg_wr_in) begin
      if (reg_addr_in == {1'b0, ADDR_TEST_MODE_CONFIG}) test_mode_config_q <= reg_wdata_in;
      if (reg_addr_in == {1'b0, ADDR_INTERRUPT_MASK}) interrupt_mask_q <= reg_wdata_in;
      if (reg_addr_in == {1'b0, ADDR_FAST_LINK_CONFIG}) fast_link_config_q <= reg_wdata_in;
      if (reg_addr_in == ADDR_PORT_FEATURE_CONFIG) port_feature_config_q <= reg_wdata_in;
    end
  end

  energy_detector u_ed (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .strength_in  (strength_in),
    .threshold_in (port_feature_config_q[PF_ED_LSB +: 4]),
    .listen_in    (port_feature_config_q[PF_EL_LSB +: 4]),
    .energy_out   (energy)
  );

  assign fast_mode = fast_link_config_q[FL_FAST_DOWN];
  assign crit_hit  = fast_mode &&
                     |(loss_crit_in[3:0] & fast_link_config_q[FL_FLD_LSB +: 4]) ||
                     fast_mode && fast_link_config_q[FL_FLD_LSB + 4] && !energy;
  assign win_len   = fast_mode ? 32'(WIN_FAST_CYC) :
                     (speed_q == SPD_1000 ? 32'(WIN_1000_CYCLES) : 32'(WIN_100_CYCLES));
  assign win_end   = win_cnt_q >= win_len;
  assign loss_ev   = !link_down_out && (crit_hit || (win_end && !seen_q && !rx_activity_in));
  assign mirror_en = port_feature_config_q[PF_MIRROR];
  assign test_mode = test_mode_config_q[TM_LSB +: 3];
  assign wr_sts    = reg_rd_in && reg_addr_in == {1'b0, ADDR_INTERRUPT_STATUS};

  // Search window: a window with no receive activity declares loss
  // A declared drop holds until the link itself goes away, so it cannot flicker
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      win_cnt_q     <= 32'h0000_0000;
      seen_q        <= 1'b0;
      drop_q        <= 1'b0;
      link_down_out <= 1'b1;
    end else if (!link_ok_in || loss_ev) begin
      win_cnt_q     <= 32'h0000_0000;
      seen_q        <= 1'b0;
      drop_q        <= loss_ev && link_ok_in;
      link_down_out <= 1'b1;
    end else begin
      link_down_out <= drop_q;
      win_cnt_q     <= win_end ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
      seen_q        <= win_end ? 1'b0 : (seen_q || rx_activity_in);
    end
  end

  // Downshift: count failed attempts at the current speed
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      speed_q    <= SPD_1000;
      fail_cnt_q <= 3'h0;
    end else if (soft_rst_in || !port_feature_config_q[PF_SPD_EN]) begin
      speed_q    <= SPD_1000;
      fail_cnt_q <= 3'h0;
    end else if (link_ok_in) begin
      fail_cnt_q <= 3'h0;
    end else if (attempt_fail_in && speed_q != SPD_10) begin
      if (down_ev) begin
        speed_q    <= (speed_q == SPD_1000) ? SPD_100 : SPD_10;
        fail_cnt_q <= 3'h0;
      end else begin
        fail_cnt_q <= fail_cnt_q + 3'h1;
      end
    end
  end
  assign down_ev = attempt_fail_in && !link_ok_in && port_feature_config_q[PF_SPD_EN] &&
                   !soft_rst_in && speed_q != SPD_10 &&
                   (fail_cnt_q >= port_feature_config_q[PF_ATT_LSB +: 3] ||
                    (speed_q == SPD_1000 && port_feature_config_q[PF_SPD_ENH] && !energy_cd_in));

  // Sticky status: a new event wins over the clear-on-read
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      interrupt_status_q <= 16'h0000;
      energy_q           <= 1'b0;
      irq_out            <= 1'b0;
    end else begin
      energy_q <= energy;
      interrupt_status_q <= (wr_sts ? 16'h0000 : interrupt_status_q)
                          | 16'({energy != energy_q, down_ev, loss_ev});
      irq_out <= |(interrupt_status_q & interrupt_mask_q);
    end
  end

  // Port mapping and test patterns; the clock follows the pattern source
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_out <= 4'h0;
      clk_out  <= 1'b0;
    end else begin
      if (test_mode != 3'(TM_NORMAL) && test_mode <= 3'(TM_4)) begin
        port_out <= mirror_en ? mirror_map(pattern_in, SPD_1000) : pattern_in;
        clk_out  <= tx_clk_in;
      end else begin
        port_out <= mirror_en ? mirror_map(port_tx_in, speed_q) : port_tx_in;
        clk_out  <= 1'b0;
      end
    end
  end

  // Cable length only tracks while the link is up; pinout does not matter here
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cable_len_q <= 8'h00;
    end else if (link_ok_in && !link_down_out) begin
      cable_len_q <= adapt_len_in;
    end
  end

  // Register read port and straight outputs
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
      speed_out     <= 2'(SPD_1000);
      fast_1000_out <= 1'b0;
      fast_100_out  <= 1'b0;
    end else begin
      speed_out     <= 2'(speed_q);
      fast_1000_out <= fast_link_config_q[FL_FAST_1000];
      fast_100_out  <= fast_link_config_q[FL_FAST_100];
      unique case (reg_addr_in)
        {1'b0, ADDR_TEST_MODE_CONFIG}: reg_rdata_out <= test_mode_config_q;
        {1'b0, ADDR_INTERRUPT_MASK}:   reg_rdata_out <= interrupt_mask_q;
        {1'b0, ADDR_INTERRUPT_STATUS}: reg_rdata_out <= interrupt_status_q;
        {1'b0, ADDR_FAST_LINK_CONFIG}: reg_rdata_out <= fast_link_config_q;
        ADDR_PORT_FEATURE_CONFIG:      reg_rdata_out <= port_feature_config_q;
        ADDR_CABLE_LENGTH:             reg_rdata_out <= {8'h00, cable_len_q};
        default:                       reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  a_loss_sets_down: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    loss_ev |=> link_down_out) else $error("loss did not drop link");
  a_loss_latched: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    loss_ev |=> interrupt_status_q[IS_LINK_LOSS]) else $error("loss not latched");
  a_down_latched: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    down_ev |=> interrupt_status_q[IS_DOWNSHIFT]) else $error("downshift not latched");
  a_gig_to_100: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    down_ev && speed_q == SPD_1000 |=> speed_q == SPD_100) else $error("no 100 fallback");
  a_100_to_10: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    down_ev && speed_q == SPD_100 |=> speed_q == SPD_10) else $error("no 10 fallback");
  a_enh_one_fail: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    attempt_fail_in && !link_ok_in && !soft_rst_in && speed_q == SPD_1000 &&
    port_feature_config_q[PF_SPD_EN] && port_feature_config_q[PF_SPD_ENH] && !energy_cd_in
    |=> speed_q == SPD_100) else $error("enhanced downshift missed");
  a_irq_follows: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    |(interrupt_status_q & interrupt_mask_q) |=> irq_out) else $error("irq missing");
  a_fast_window: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fast_mode |-> win_len == 32'(WIN_FAST_CYC)) else $error("fast window wrong");
  a_mirror_gig: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    mirror_en && speed_q == SPD_1000 && test_mode == 3'(TM_NORMAL)
    |=> port_out == {$past(port_tx_in[0]), $past(port_tx_in[1]),
                     $past(port_tx_in[2]), $past(port_tx_in[3])})
    else $error("gigabit mirror wrong");
  a_test_clock: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    test_mode == 3'(TM_1) && $stable(test_mode) |=> clk_out == $past(tx_clk_in))
    else $error("test clock wrong");

  c_loss: cover property (@(posedge clock_in) disable iff (sys_rst_in) loss_ev);
  c_to_10: cover property (@(posedge clock_in) disable iff (sys_rst_in) speed_q == SPD_10);
  c_irq: cover property (@(posedge clock_in) disable iff (sys_rst_in) $rose(irq_out));
endmodule // phy_link_supervision

/* rtl/phy_link_supervision_pkg.sv */
// Constants and types shared by the link-supervision block
package phy_link_supervision_pkg;
  // Management register addresses
  localparam logic [4:0] ADDR_TEST_MODE_CONFIG    = 5'h09;
  localparam logic [4:0] ADDR_INTERRUPT_MASK      = 5'h12;
  localparam logic [4:0] ADDR_INTERRUPT_STATUS    = 5'h13;
  localparam logic [4:0] ADDR_FAST_LINK_CONFIG    = 5'h1E;
  localparam logic [5:0] ADDR_PORT_FEATURE_CONFIG = 6'h31;
  localparam logic [5:0] ADDR_CABLE_LENGTH        = 6'h3A;
  // Reset values
  localparam logic [15:0] RST_TEST_MODE_CONFIG    = 16'h0000;
  localparam logic [15:0] RST_INTERRUPT_MASK      = 16'h0000;
  localparam logic [15:0] RST_FAST_LINK_CONFIG    = 16'h0000;
  localparam logic [15:0] RST_PORT_FEATURE_CONFIG = 16'h0000;
  // Field positions
  localparam int TM_LSB        = 13;  // test_mode_config[15:13]
  localparam int FL_FLD_LSB    = 0;   // fast_link_config[4:0] criterion enables
  localparam int FL_FAST_DOWN  = 10;  // fast link-down enable
  localparam int FL_FAST_1000  = 11;  // fast establishment, gigabit
  localparam int FL_FAST_100   = 12;  // fast establishment, 100
  localparam int PF_MIRROR     = 0;   // port mirror enable
  localparam int PF_SPD_EN     = 1;   // speed optimization enable
  localparam int PF_SPD_ENH    = 2;   // enhanced speed optimization
  localparam int PF_ATT_LSB    = 3;   // port_feature_config[5:3] attempts-1
  localparam int PF_ED_LSB     = 8;   // energy threshold [11:8]
  localparam int PF_EL_LSB     = 12;  // listening time [15:12]
  localparam logic [2:0] RST_ATTEMPTS_M1 = 3'h3; // four attempts
  // Interrupt status bits
  localparam int IS_LINK_LOSS = 0;
  localparam int IS_DOWNSHIFT = 1;
  localparam int IS_ENERGY    = 2;
  // Timing
  localparam int  CLK_MHZ      = 40;
  localparam real WIN_100_MS   = 1.0;
  localparam real WIN_1000_MS  = 0.5;
  localparam real WIN_FAST_US  = 10.0;
  localparam int  WIN_100_CYC  = int'(WIN_100_MS * 1000.0 * CLK_MHZ) - 1;
  localparam int  WIN_1000_CYC = int'(WIN_1000_MS * 1000.0 * CLK_MHZ) - 1;
  localparam int  WIN_FAST_CYC = int'(WIN_FAST_US * CLK_MHZ) - 1;
  localparam int  ED_HYST      = 2;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
  typedef enum logic [2:0] {TM_NORMAL, TM_1, TM_2, TM_3, TM_4} test_mode_t;
endpackage

/* verification/link_partner_model.sv */
// Remote link partner model: receive activity, signal strength, failed link attempts
module link_partner_model (
  input  wire logic       clock_in,
  input  wire logic       active_in,
  input  wire logic       energy_cd_en_in,
  output logic            rx_activity_out,
  output logic [7:0]      strength_out,
  output logic            energy_cd_out,
  output logic [7:0]      adapt_len_out,
  output logic            attempt_fail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_activity_out = 1'b0;
    strength_out = 8'h00;
    energy_cd_out = 1'b0;
    adapt_len_out = 8'h00;
    attempt_fail_out = 1'b0;
  end
  // A silent partner shows a weak, changing strength rather than a frozen value
  always @(negedge clock_in) begin
    rx_activity_out <= active_in;
    strength_out <= active_in ? 8'hC0 : 8'($urandom_range(0, 7));
    energy_cd_out <= energy_cd_en_in;
    adapt_len_out <= 8'($urandom);
  end
  // One failed attempt is a single-cycle pulse, spaced so each is seen alone
  task automatic fail_attempts(input int n);
    repeat (n) begin
      @(negedge clock_in);
      attempt_fail_out = 1'b1;
      @(negedge clock_in);
      attempt_fail_out = 1'b0;
      repeat (3) @(negedge clock_in);
    end
  endtask
endmodule // link_partner_model

/* verification/tb_phy_link_supervision.sv */
// Self-checking bench for the link-supervision block
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_phy_link_supervision;
  import phy_link_supervision_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; int sel; logic [15:0] m; logic [15:0] e;} note_t;
  logic        clock_in = 0, sys_rst_in = 1, soft_rst_in = 0, strap_mirror_in = 1;
  logic        reg_wr_in = 0, reg_rd_in = 0, link_ok_in = 0, straight_pinout_in = 0;
  logic        tx_clk_in = 0, active = 0, cd_en = 1, rx_activity, energy_cd, attempt_fail;
  logic [5:0]  reg_addr_in = 6'h00;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, got;
  logic [4:0]  loss_crit_in = 5'h00;
  logic [3:0]  port_tx_in = 4'h0, pattern_in = 4'h0, port_out, v;
  logic [7:0]  strength, adapt_len;
  logic [1:0]  speed_out;
  logic        link_down_out, clk_out, fast_1000_out, fast_100_out, irq_out;
  int          err_count = 0, n_checks = 0, cyc;
  note_t       notes[$], n;
  event        ev;
  localparam logic [5:0] TM = 6'(ADDR_TEST_MODE_CONFIG), MK = 6'(ADDR_INTERRUPT_MASK);
  localparam logic [5:0] ST = 6'(ADDR_INTERRUPT_STATUS), FL = 6'(ADDR_FAST_LINK_CONFIG);
  localparam logic [5:0] PF = ADDR_PORT_FEATURE_CONFIG;
  always #12.5 clock_in = ~clock_in;
  phy_link_supervision #(.WIN_100_CYCLES(50), .WIN_1000_CYCLES(25)) i_phy_link_supervision (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
    .strap_mirror_in(strap_mirror_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .loss_crit_in(loss_crit_in),
    .rx_activity_in(rx_activity), .link_ok_in(link_ok_in), .attempt_fail_in(attempt_fail),
    .strength_in(strength), .energy_cd_in(energy_cd), .adapt_len_in(adapt_len),
    .straight_pinout_in(straight_pinout_in), .port_tx_in(port_tx_in),
    .pattern_in(pattern_in), .tx_clk_in(tx_clk_in), .reg_rdata_out(reg_rdata_out),
    .link_down_out(link_down_out), .speed_out(speed_out), .port_out(port_out),
    .clk_out(clk_out), .fast_1000_out(fast_1000_out), .fast_100_out(fast_100_out),
    .irq_out(irq_out));
  link_partner_model i_link_partner_model (
    .clock_in(clock_in), .active_in(active), .energy_cd_en_in(cd_en),
    .rx_activity_out(rx_activity), .strength_out(strength), .energy_cd_out(energy_cd),
    .adapt_len_out(adapt_len), .attempt_fail_out(attempt_fail));
  // Pinout, pattern and pattern clock wander freely; the mapping must not care
  always @(negedge clock_in) begin
    straight_pinout_in <= 1'($urandom);
    pattern_in <= 4'($urandom);
    tx_clk_in <= ~tx_clk_in;
  end
  always @(ev) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        0: got = reg_rdata_out;
        1: got = {15'h0000, link_down_out};
        2: got = {14'h0000, speed_out};
        3: got = {12'h000, port_out};
        4: got = {15'h0000, irq_out};
        default: got = {14'h0000, fast_1000_out, fast_100_out};
      endcase
      `CHK(n.nm, n.e, got & n.m)
    end
  end
  task automatic note(input string nm, input int sel, input logic [15:0] m, e);
    notes.push_back('{nm, sel, m, e});
    -> ev;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clock_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
    @(negedge clock_in);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] m, e);
    @(negedge clock_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    note("rdata", 0, m, e);
  endtask
  task automatic soft_reset();
    @(negedge clock_in);
    soft_rst_in = 1'b1;
    @(negedge clock_in);
    soft_rst_in = 1'b0;
    @(negedge clock_in);
  endtask
  task automatic port_chk(input logic [3:0] e);
    @(negedge clock_in);
    note("port", 3, 16'h000F, {12'h000, e});
  endtask
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(51896));
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge clock_in);
    strap_mirror_in = 1'b0;
    rd(TM, 16'hFFFF, RST_TEST_MODE_CONFIG);
    rd(MK, 16'hFFFF, RST_INTERRUPT_MASK);
    rd(FL, 16'hFFFF, RST_FAST_LINK_CONFIG);
    rd(PF, 16'hFFFF, 16'h0019);
    rd(6'h20, 16'hFFFF, 16'h0000);
    wr(PF, 16'h0000);
    soft_reset();
    rd(PF, 16'hFFFF, 16'h0019);
    for (int k = 0; k < 5; k++) begin
      wr(TM, 16'(k << 13));
      rd(TM, 16'hE000, 16'(k << 13));
    end
    for (int k = 1; k < 4; k++) begin
      wr(FL, 16'(k << 11));
      note("fast", 5, 16'h0003, {14'h0000, 1'(k), 1'(k >> 1)});
    end
    v = 4'($urandom);
    wr(MK, {12'h000, v});
    rd(MK, 16'hFFFF, {12'h000, v});
    wr(FL, 16'h0000);
    wr(MK, 16'h0001);
    active = 1'b1;
    link_ok_in = 1'b1;
    repeat (20) @(negedge clock_in);
    rd(ST, 16'h0000, 16'h0000);
    note("link_down", 1, 16'h0001, 16'h0000);
    active = 1'b0;
    repeat (15) @(negedge clock_in);
    note("link_down", 1, 16'h0001, 16'h0000);
    for (cyc = 0; cyc < 80 && link_down_out !== 1'b1; cyc++) @(negedge clock_in);
    note("link_down", 1, 16'h0001, 16'h0001);
    repeat (2) @(negedge clock_in);
    note("irq", 4, 16'h0001, 16'h0001);
    rd(ST, 16'h0001, 16'h0001);
    rd(ST, 16'h0001, 16'h0000);
    repeat (2) @(negedge clock_in);
    note("irq", 4, 16'h0001, 16'h0000);
    active = 1'b1;
    for (int i = 0; i < 4; i++) begin
      link_ok_in = 1'b0;
      repeat (2) @(negedge clock_in);
      link_ok_in = 1'b1;
      wr(FL, 16'h0400 | 16'(1 << i));
      loss_crit_in = 5'(1 << ((i + 1) % 4));
      repeat (4) @(negedge clock_in);
      note("link_down", 1, 16'h0001, 16'h0000);
      loss_crit_in = 5'(1 << i);
      repeat (4) @(negedge clock_in);
      note("link_down", 1, 16'h0001, 16'h0001);
      loss_crit_in = 5'h00;
    end
    soft_reset();
    link_ok_in = 1'b0;
    wr(PF, 16'h001A);
    i_link_partner_model.fail_attempts(3);
    note("speed", 2, 16'h0003, 16'h0002);
    i_link_partner_model.fail_attempts(1);
    note("speed", 2, 16'h0003, 16'h0001);
    i_link_partner_model.fail_attempts(4);
    note("speed", 2, 16'h0003, 16'h0000);
    rd(ST, 16'h0002, 16'h0002);
    soft_reset();
    wr(PF, 16'h0018);
    v = 4'($urandom);
    port_tx_in = v;
    port_chk(v);
    wr(PF, 16'h0019);
    repeat (4) begin
      v = 4'($urandom);
      port_tx_in = v;
      port_chk({v[0], v[1], v[2], v[3]});
    end
    wr(PF, 16'h001F);
    cd_en = 1'b0;
    i_link_partner_model.fail_attempts(1);
    note("speed", 2, 16'h0003, 16'h0001);
    repeat (4) begin
      v = 4'($urandom);
      port_tx_in = v;
      port_chk({v[0], v[1], 2'b00});
    end
    repeat (3) @(negedge clock_in);
    wrap_up();
  end
endmodule // tb_phy_link_supervision
